// file: verilog/fcag_consts.svh
`ifndef FCAG_CONSTS_SVH
`define FCAG_CONSTS_SVH

// control addresses and fill area of the device
`define FCAG_ADDR_PCTL     17'h0ff80
`define FCAG_ADDR_EBS1     17'h0ff82
`define FCAG_ADDR_EBS2     17'h0ff83
`define FCAG_FILL_LO       17'h0f780
`define FCAG_FILL_BYTE     8'hff
`define FCAG_PCTL_RST      8'h80
`define FCAG_EBS_RST       8'h00
`define FCAG_PCTL_HV_BIT   7
`define FCAG_PCTL_P_BIT    0
`define FCAG_PCTL_E_BIT    1

// controller register offsets
`define FCAG_OFF_CTRL      8'h00
`define FCAG_OFF_ADDR      8'h04
`define FCAG_OFF_WDATA     8'h08
`define FCAG_OFF_CMD       8'h0c
`define FCAG_OFF_STATUS    8'h10
`define FCAG_OFF_IRQ_ST    8'h14
`define FCAG_OFF_IRQ_CLR   8'h18
`define FCAG_OFF_IRQ_EN    8'h1c

// controller field positions
`define FCAG_CTRL_HV_BIT   2
`define FCAG_CTRL_STANDBY_REQUEST_PIN_BIT 3
`define FCAG_CTRL_WDOG_BIT 4
`define FCAG_CMD_GO_BIT    0
`define FCAG_CMD_WR_BIT    1
`define FCAG_ST_BUSY_BIT   8
`define FCAG_ST_EXT_BIT    9
`define FCAG_ST_HV_BIT     10
`define FCAG_ST_STANDBY_REQUEST_PIN_BIT   11
`define FCAG_IRQ_BUS_BIT   0
`define FCAG_IRQ_SUP_BIT   1
`define FCAG_IRQ_WDOG_BIT  2
`define FCAG_IRQ_PWR_BIT   3

// timing
`define FCAG_CLK_HZ        20000000
`define FCAG_RES_HOLD_CYC  10
`define FCAG_OSC_SETTLE_MS 20
`define FCAG_OSC_SETTLE_CYC ((`FCAG_OSC_SETTLE_MS * `FCAG_CLK_HZ) / 1000)
`define FCAG_PE_MAX_US     1000
`define FCAG_PE_MAX_CYC    ((`FCAG_PE_MAX_US * (`FCAG_CLK_HZ / 1000)) / 1000)

`endif

// file: verilog/fcag_pkg.sv
package fcag_pkg;

  // operating mode pins
  typedef enum logic [1:0]
  {
    FCAG_MODE_PROG = 2'h0,
    FCAG_MODE_1    = 2'h1,
    FCAG_MODE_2    = 2'h2,
    FCAG_MODE_3    = 2'h3
  } fcag_mode_e;

  // where a bus access lands
  typedef enum logic [1:0]
  {
    FCAG_RT_ARRAY = 2'h0,
    FCAG_RT_REG   = 2'h1,
    FCAG_RT_FILL  = 2'h2,
    FCAG_RT_EXT   = 2'h3
  } fcag_route_e;

  // controller sequencer
  typedef enum logic [2:0]
  {
    FCAG_HS_POWERUP = 3'h0,
    FCAG_HS_IDLE    = 3'h1,
    FCAG_HS_BUS     = 3'h3,
    FCAG_HS_HOLD    = 3'h5,
    FCAG_HS_SWITCH  = 3'h4
  } fcag_hstate_e;

endpackage

// file: verilog/fcag_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fcag_link_if;
  // pins from the controller
  logic        rstPinN;
  logic        supplyHigh;
  logic        supplyLow;
  logic [1:0]  modeSel;
  // byte bus from the controller
  logic        busReq;
  logic        busWrite;
  logic [16:0] busAddr;
  logic [7:0]  busWdata;
  // answers and state from the device
  logic        busAck;
  logic [7:0]  busRdata;
  logic        busExt;
  logic        hvFlag;
  logic        standby;

  modport device
  (
    input  rstPinN, supplyHigh, supplyLow, modeSel, busReq, busWrite, busAddr, busWdata,
    output busAck, busRdata, busExt, hvFlag, standby
  );
  modport host
  (
    output rstPinN, supplyHigh, supplyLow, modeSel, busReq, busWrite, busAddr, busWdata,
    input  busAck, busRdata, busExt, hvFlag, standby
  );
endinterface
`default_nettype wire

// file: verilog/fcag_device_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcag_consts.svh"

// Behaviour
// - unused high addresses read all ones
// - flag follows supply above threshold
// - flag set allows control register writes
// - three control registers at fixed addresses
// - flag set: registers modes 2/3, fill mode 1
// - no flag: external modes 1/2, fill mode 3
// - mode 2 with flag: read and write
// - supply pin low enters hardware standby
// - controller holds reset ten cycles first
// - power-up reset held for oscillator settling
// - program/erase bits clear at supply change
// - no array reads during supply change
// - watchdog started before program/erase bits; the controller arms it one cycle after the write sets them
// - reserved area ignores writes, reads ones
module fcag_device_end
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // link to the programming controller
  fcag_link_if.device      link,
  // array and external space
  input  wire logic [7:0]  arrayRdata,
  input  wire logic [7:0]  extRdata,
  output logic      [16:0] accAddr,
  output logic      [7:0]  accWdata,
  output logic             extSel,
  output logic             extWrite,
  // state towards the flash core
  output logic      [7:0]  progCtrl,
  output logic      [7:0]  eraseSel1,
  output logic      [7:0]  eraseSel2,
  output logic             hwStandby
);

  localparam int unsigned PIN_W = 5;

  logic [PIN_W-1:0]     pinRaw;
  logic [PIN_W-1:0]     pinMeta_reg;
  logic [PIN_W-1:0]     pinSync_reg;
  logic                 rstPinN;
  logic                 hvFlag;
  logic                 standby;
  fcag_pkg::fcag_mode_e mode;
  logic                 ctlRst;
  logic                 isCtlAddr;
  fcag_pkg::fcag_route_e route;
  logic                 take;
  logic                 regWrite;
  logic                 ack_reg;
  logic [7:0]           rdata_reg;
  logic                 ext_reg;
  logic [7:0]           pctl_reg;
  logic [7:0]           ebs1_reg;
  logic [7:0]           ebs2_reg;
  logic [7:0]           regRead;

  // pins come from another party, so every bit passes two flops
  assign pinRaw = {link.modeSel, link.supplyHigh, link.supplyLow, link.rstPinN};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : gSync
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          pinMeta_reg[gi] <= 1'b0;
          pinSync_reg[gi] <= 1'b0;
        end
        else
        begin
          pinMeta_reg[gi] <= pinRaw[gi];
          pinSync_reg[gi] <= pinMeta_reg[gi];
        end
      end
    end
  endgenerate

  // decoded pin levels
  assign rstPinN = pinSync_reg[0];
  assign standby = pinSync_reg[1];
  assign hvFlag  = pinSync_reg[2] & ~pinSync_reg[1];
  assign mode    = fcag_pkg::fcag_mode_e'(pinSync_reg[4:3]);

  // reset pin and standby both put the control registers back
  assign ctlRst = ~rstPinN | standby;

  // control address match
  assign isCtlAddr = (link.busAddr == `FCAG_ADDR_PCTL) ||
                     (link.busAddr == `FCAG_ADDR_EBS1) ||
                     (link.busAddr == `FCAG_ADDR_EBS2);

  // address decode per mode and supply flag
  always_comb
  begin
    route = fcag_pkg::FCAG_RT_ARRAY;
    if (isCtlAddr)
    begin
      if (hvFlag)
      begin
        case (mode)
          fcag_pkg::FCAG_MODE_2: route = fcag_pkg::FCAG_RT_REG;
          fcag_pkg::FCAG_MODE_3: route = fcag_pkg::FCAG_RT_REG;
          default:               route = fcag_pkg::FCAG_RT_FILL;
        endcase
      end
      else
      begin
        case (mode)
          fcag_pkg::FCAG_MODE_1: route = fcag_pkg::FCAG_RT_EXT;
          fcag_pkg::FCAG_MODE_2: route = fcag_pkg::FCAG_RT_EXT;
          default:               route = fcag_pkg::FCAG_RT_FILL;
        endcase
      end
    end
    else if (mode == fcag_pkg::FCAG_MODE_1)
    begin
      // on-chip rom is off in this mode
      route = fcag_pkg::FCAG_RT_EXT;
    end
    else if (link.busAddr >= `FCAG_FILL_LO)
    begin
      route = fcag_pkg::FCAG_RT_FILL;
    end
    else
    begin
      route = fcag_pkg::FCAG_RT_ARRAY;
    end
  end

  // one access taken per request; none in reset or standby
  assign take     = link.busReq & ~ack_reg & ~ctlRst;
  assign regWrite = take & link.busWrite & hvFlag &
                    (route == fcag_pkg::FCAG_RT_REG);

  // array and external space see the address directly
  assign accAddr  = link.busAddr;
  assign accWdata = link.busWdata;
  assign extSel   = take & (route == fcag_pkg::FCAG_RT_EXT);
  assign extWrite = extSel & link.busWrite;

  // control register read value
  always_comb
  begin
    case (link.busAddr)
      `FCAG_ADDR_PCTL: regRead = pctl_reg;
      `FCAG_ADDR_EBS1: regRead = ebs1_reg;
      `FCAG_ADDR_EBS2: regRead = ebs2_reg;
      default:         regRead = `FCAG_FILL_BYTE;
    endcase
  end

  // answer one cycle after the request is taken
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= take;
    end
  end

  // read data and route flag of the answer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_reg <= 8'h00;
      ext_reg   <= 1'b0;
    end
    else if (take)
    begin
      ext_reg <= (route == fcag_pkg::FCAG_RT_EXT);
      case (route)
        fcag_pkg::FCAG_RT_REG:   rdata_reg <= regRead;
        fcag_pkg::FCAG_RT_FILL:  rdata_reg <= `FCAG_FILL_BYTE;
        fcag_pkg::FCAG_RT_EXT:   rdata_reg <= extRdata;
        default:                 rdata_reg <= arrayRdata;
      endcase
    end
  end

  // program control: top bit mirrors the supply flag outside reset pin and standby, which set it
  always_ff @(posedge clk)
  begin
    if (!reset_n || ctlRst)
    begin
      pctl_reg <= `FCAG_PCTL_RST;
    end
    else
    begin
      pctl_reg[`FCAG_PCTL_HV_BIT] <= hvFlag;
      if (!hvFlag)
      begin
        // dropping the supply also drops any program or erase bit
        pctl_reg[6:0] <= 7'(`FCAG_PCTL_RST);
      end
      else if (regWrite && link.busAddr == `FCAG_ADDR_PCTL)
      begin
        pctl_reg[6:0] <= link.busWdata[6:0];
      end
    end
  end

  // erase block selects
  always_ff @(posedge clk)
  begin
    if (!reset_n || ctlRst || !hvFlag)
    begin
      ebs1_reg <= `FCAG_EBS_RST;
      ebs2_reg <= `FCAG_EBS_RST;
    end
    else if (regWrite)
    begin
      if (link.busAddr == `FCAG_ADDR_EBS1)
      begin
        ebs1_reg <= link.busWdata;
      end
      if (link.busAddr == `FCAG_ADDR_EBS2)
      begin
        ebs2_reg <= link.busWdata;
      end
    end
  end

  // outputs
  assign link.busAck   = ack_reg;
  assign link.busRdata = rdata_reg;
  assign link.busExt   = ext_reg;
  assign link.hvFlag   = hvFlag;
  assign link.standby  = standby;
  assign progCtrl      = pctl_reg;
  assign eraseSel1     = ebs1_reg;
  assign eraseSel2     = ebs2_reg;
  assign hwStandby     = standby;

endmodule // fcag_device_end
`default_nettype wire

// file: verilog/fcag_host_end.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fcag_consts.svh"

module fcag_host_end
#(
  parameter int unsigned OSC_SETTLE_CYC = `FCAG_OSC_SETTLE_CYC,
  parameter int unsigned WDOG_CYC       = `FCAG_PE_MAX_CYC
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // interrupt
  output logic             irq,
  // link to the device
  fcag_link_if.host        link
);

  fcag_pkg::fcag_hstate_e state_reg;
  logic [18:0] cnt_reg;
  logic [14:0] wdogCnt_reg;
  logic        wdogArmed_reg, wdogFire_reg, goPend_reg, goWr_reg;
  logic [4:0]  ctrl_reg;
  logic [16:0] addr_reg;
  logic [7:0]  wdat_reg, rdat_reg;
  logic        ext_reg, rstPin_reg, hv_reg, low_reg, req_reg;
  logic [7:0]  reqWdata_reg;
  logic [3:0]  irqSt_reg, irqEn_reg, evt;
  logic [31:0] wmask, rmux;
  logic        wr, supDiff, peSet;

  // writes need both channels; the response follows both
  assign wr      = awvalid & wvalid & ~bvalid;
  assign awready = wr;
  assign wready  = wr;
  assign arready = ~rvalid;
  assign wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign supDiff = (hv_reg != ctrl_reg[`FCAG_CTRL_HV_BIT]) |
                   (low_reg != ctrl_reg[`FCAG_CTRL_STANDBY_REQUEST_PIN_BIT]);
  assign peSet   = wdat_reg[`FCAG_PCTL_P_BIT] | wdat_reg[`FCAG_PCTL_E_BIT];

  // write response
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      bvalid <= 1'b0;
    else if (wr)
      bvalid <= 1'b1;
    else if (bready)
      bvalid <= 1'b0;
  end
  assign bresp = 2'h0;

  // software registers, byte lanes honoured
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= 5'h00;
      addr_reg <= 17'h00000;
      wdat_reg <= 8'h00;
      irqEn_reg <= 4'h0;
    end
    else if (wr)
    begin
      case (awaddr)
        `FCAG_OFF_CTRL:   ctrl_reg  <= (ctrl_reg & ~wmask[4:0]) | (wdata[4:0] & wmask[4:0]);
        `FCAG_OFF_ADDR:   addr_reg  <= (addr_reg & ~wmask[16:0]) | (wdata[16:0] & wmask[16:0]);
        `FCAG_OFF_WDATA:  wdat_reg  <= (wdat_reg & ~wmask[7:0]) | (wdata[7:0] & wmask[7:0]);
        `FCAG_OFF_IRQ_EN: irqEn_reg <= (irqEn_reg & ~wmask[3:0]) | (wdata[3:0] & wmask[3:0]);
        default:          ctrl_reg  <= ctrl_reg;
      endcase
    end
  end

  // read mux, unmapped reads zero with slave error
  always_comb
  begin
    rmux = 32'h00000000;
    case (araddr)
      `FCAG_OFF_CTRL:   rmux[4:0]  = ctrl_reg;
      `FCAG_OFF_ADDR:   rmux[16:0] = addr_reg;
      `FCAG_OFF_WDATA:  rmux[7:0]  = wdat_reg;
      `FCAG_OFF_STATUS: rmux[11:0] = {link.standby, link.hvFlag, ext_reg,
                                      goPend_reg | (state_reg != fcag_pkg::FCAG_HS_IDLE),
                                      rdat_reg};
      `FCAG_OFF_IRQ_ST: rmux[3:0]  = irqSt_reg;
      `FCAG_OFF_IRQ_EN: rmux[3:0]  = irqEn_reg;
      default:          rmux       = 32'h00000000;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= 2'h0;
    end
    else if (arvalid && !rvalid)
    begin
      rvalid <= 1'b1;
      rdata  <= rmux;
      rresp  <= (araddr == `FCAG_OFF_CMD || araddr == `FCAG_OFF_IRQ_CLR ||
                 araddr > `FCAG_OFF_IRQ_EN || araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // command pending; a command while one is pending or a bus access runs is ignored
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      goPend_reg <= 1'b0;
      goWr_reg   <= 1'b0;
    end
    else if (wr && awaddr == `FCAG_OFF_CMD && wstrb[0] && wdata[`FCAG_CMD_GO_BIT] &&
             !goPend_reg && state_reg != fcag_pkg::FCAG_HS_BUS)
    begin
      goPend_reg <= 1'b1;
      goWr_reg   <= wdata[`FCAG_CMD_WR_BIT];
    end
    else if (state_reg == fcag_pkg::FCAG_HS_IDLE && !supDiff && !wdogFire_reg &&
             !low_reg)
      goPend_reg <= 1'b0;
  end

  // sequencer: reset pin, supply level and bus accesses
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= fcag_pkg::FCAG_HS_POWERUP;
      cnt_reg <= 19'h00000;
      rstPin_reg <= 1'b0;
      hv_reg <= 1'b0;
      low_reg <= 1'b0;
      req_reg <= 1'b0;
      reqWdata_reg <= 8'h00;
      rdat_reg <= 8'h00;
      ext_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        fcag_pkg::FCAG_HS_POWERUP:
          if (cnt_reg >= 19'(OSC_SETTLE_CYC - 1))
          begin
            rstPin_reg <= 1'b1;
            state_reg <= fcag_pkg::FCAG_HS_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 19'h00001;
        fcag_pkg::FCAG_HS_IDLE:
          if (supDiff || wdogFire_reg)
          begin
            rstPin_reg <= 1'b0;
            cnt_reg <= 19'h00000;
            state_reg <= fcag_pkg::FCAG_HS_HOLD;
          end
          else if (goPend_reg && !low_reg)
          begin
            req_reg <= 1'b1;
            // program/erase bits pass only with the watchdog on
            reqWdata_reg <= (addr_reg == `FCAG_ADDR_PCTL && !ctrl_reg[`FCAG_CTRL_WDOG_BIT]) ?
              (wdat_reg & 8'hfc) : wdat_reg;
            state_reg <= fcag_pkg::FCAG_HS_BUS;
          end
        fcag_pkg::FCAG_HS_BUS:
          if (link.busAck)
          begin
            req_reg <= 1'b0;
            rdat_reg <= link.busRdata;
            ext_reg <= link.busExt;
            state_reg <= fcag_pkg::FCAG_HS_IDLE;
          end
        fcag_pkg::FCAG_HS_HOLD:
          if (cnt_reg >= 19'(`FCAG_RES_HOLD_CYC - 1))
          begin
            // device held in reset, so its program/erase bits are clear
            hv_reg <= ctrl_reg[`FCAG_CTRL_HV_BIT];
            low_reg <= ctrl_reg[`FCAG_CTRL_STANDBY_REQUEST_PIN_BIT];
            cnt_reg <= 19'h00000;
            state_reg <= fcag_pkg::FCAG_HS_SWITCH;
          end
          else
            cnt_reg <= cnt_reg + 19'h00001;
        fcag_pkg::FCAG_HS_SWITCH:
          if (cnt_reg >= 19'(`FCAG_RES_HOLD_CYC - 1))
          begin
            rstPin_reg <= 1'b1;
            state_reg <= fcag_pkg::FCAG_HS_IDLE;
          end
          else
            cnt_reg <= cnt_reg + 19'h00001;
        default:
          state_reg <= fcag_pkg::FCAG_HS_POWERUP;
      endcase
    end
  end

  // watchdog while program/erase bits may be set
  always_ff @(posedge clk)
  begin
    if (!reset_n || state_reg == fcag_pkg::FCAG_HS_HOLD)
    begin
      wdogArmed_reg <= 1'b0;
      wdogFire_reg <= 1'b0;
      wdogCnt_reg <= 15'h0000;
    end
    else if (state_reg == fcag_pkg::FCAG_HS_BUS && link.busAck && goWr_reg &&
             addr_reg == `FCAG_ADDR_PCTL)
    begin
      wdogArmed_reg <= peSet & ctrl_reg[`FCAG_CTRL_WDOG_BIT];
      wdogCnt_reg <= 15'h0000;
    end
    else if (wdogArmed_reg)
    begin
      if (wdogCnt_reg >= 15'(WDOG_CYC - 1))
      begin
        wdogArmed_reg <= 1'b0;
        wdogFire_reg <= 1'b1;
      end
      else
        wdogCnt_reg <= wdogCnt_reg + 15'h0001;
    end
  end

  // events; a set wins over a clear in the same cycle
  assign evt[`FCAG_IRQ_BUS_BIT]  = (state_reg == fcag_pkg::FCAG_HS_BUS) & link.busAck;
  assign evt[`FCAG_IRQ_SUP_BIT]  = (state_reg == fcag_pkg::FCAG_HS_SWITCH) & rstPin_reg == 1'b0 &
                                   (cnt_reg >= 19'(`FCAG_RES_HOLD_CYC - 1));
  assign evt[`FCAG_IRQ_WDOG_BIT] = wdogArmed_reg & (wdogCnt_reg >= 15'(WDOG_CYC - 1));
  assign evt[`FCAG_IRQ_PWR_BIT]  = (state_reg == fcag_pkg::FCAG_HS_POWERUP) &
                                   (cnt_reg >= 19'(OSC_SETTLE_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irqSt_reg <= 4'h0;
    else if (wr && awaddr == `FCAG_OFF_IRQ_CLR)
      irqSt_reg <= (irqSt_reg & ~(wdata[3:0] & wmask[3:0])) | evt;
    else
      irqSt_reg <= irqSt_reg | evt;
  end
  assign irq = |(irqSt_reg & irqEn_reg);

  // link outputs, all from flops
  assign link.rstPinN    = rstPin_reg;
  assign link.supplyHigh = hv_reg;
  assign link.supplyLow  = low_reg;
  assign link.modeSel    = ctrl_reg[1:0];
  assign link.busReq     = req_reg;
  assign link.busWrite   = goWr_reg;
  assign link.busAddr    = addr_reg;
  assign link.busWdata   = reqWdata_reg;

endmodule // fcag_host_end
`default_nettype wire

// file: tb/fcag_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fcag_link_monitor
#(
  parameter int unsigned OSC_SETTLE_CYC = 20
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // link pins and bus
  input wire logic        rstPinN,
  input wire logic        supplyHigh,
  input wire logic        supplyLow,
  input wire logic [1:0]  modeSel,
  input wire logic        busReq,
  input wire logic        busWrite,
  input wire logic [16:0] busAddr,
  input wire logic        busAck,
  input wire logic [7:0]  busRdata,
  input wire logic        busExt,
  input wire logic        hvFlag,
  input wire logic        standby
);
  logic [19:0] lowCnt;
  logic [19:0] upCnt;
  logic        ctl;
  logic        rdAck;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // control address hit and read answers
  assign ctl   = busAddr == 17'h0ff80 || busAddr == 17'h0ff82 || busAddr == 17'h0ff83;
  assign rdAck = busAck && !busWrite;

  // reset pin low time and age since reset_n release; no saturation, the run is short
  always_ff @(posedge clk)
  begin
    lowCnt <= (!reset_n || rstPinN) ? 20'h0 : lowCnt + 20'h1;
    upCnt  <= !reset_n ? 20'h0 : upCnt + 20'h1;
  end

  hv_set_a: assert property (
    $rose(hvFlag) |-> $past(supplyHigh, 2) && !$past(supplyLow, 2))
    else $error("flag without supply");
  standby_request_pin_enter_a: assert property (
    supplyLow [*4] |-> standby)
    else $error("no standby");
  reg_decode_a: assert property (
    busAck && ctl && hvFlag && modeSel[1] |-> !busExt)
    else $error("register access went out");
  ext_decode_a: assert property (
    busAck && ctl && !hvFlag && (modeSel == 2'h1 || modeSel == 2'h2) |-> busExt)
    else $error("control address not external");
  fill_ctrl_a: assert property (
    rdAck && ctl && (hvFlag ? !modeSel[1] : modeSel[0] == modeSel[1])
    |-> busRdata == 8'hff && !busExt)
    else $error("reserved area not ones");
  fill_high_a: assert property (
    rdAck && !ctl && busAddr >= 17'h0f780 && modeSel != 2'h1 |-> busRdata == 8'hff)
    else $error("high area not ones");
  supply_hold_a: assert property (
    $changed(supplyHigh) || $changed(supplyLow) |-> !rstPinN && lowCnt >= 10)
    else $error("supply moved too early");
  settle_a: assert property (
    $rose(rstPinN) || $rose(supplyHigh) |-> upCnt >= OSC_SETTLE_CYC)
    else $error("settling time cut short");
  no_read_switch_a: assert property (
    $changed(supplyHigh) || $changed(supplyLow) |-> !busReq)
    else $error("bus busy at supply change");

  cover property (rdAck && ctl && hvFlag);
  cover property ($rose(standby));
  cover property (rdAck && busExt);
endmodule // fcag_link_monitor
`default_nettype wire

// file: tb/test_flash_ctrl_reg_access_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcag_consts.svh"
module test_flash_ctrl_reg_access_gate;
  localparam int unsigned OSC = 20;
  // clock, reset and axi master side
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  // design answers and bench state
  logic        awready, wready, bvalid, arready, rvalid, irq, hwStandby;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d, st;
  logic [16:0] accAddr;
  logic [7:0]  arrayRdata, extRdata, pc, es1, es2;
  logic        sawP = 1'b0;
  logic        x;
  int          errorCnt = 0;
  int          nTests = 0;
  int          cycles = 0;
  logic [16:0] adr [4] = '{17'h0ff80, 17'h0f780, 17'h1ffff, 17'h0f77f};

  fcag_link_if lk ();

  // clock; memory data follows the address, external differs so routing shows
  always #25 clk = ~clk;
  assign arrayRdata = accAddr[7:0];
  assign extRdata   = accAddr[7:0] ^ 8'h5a;

  fcag_device_end u_fcag_device_end
  (
    .clk(clk), .reset_n(reset_n), .link(lk), .arrayRdata(arrayRdata), .extRdata(extRdata),
    .accAddr(accAddr), .accWdata(), .extSel(), .extWrite(), .progCtrl(pc),
    .eraseSel1(es1), .eraseSel2(es2), .hwStandby(hwStandby)
  );
  fcag_host_end #(.OSC_SETTLE_CYC(OSC), .WDOG_CYC(30)) u_fcag_host_end
  (
    .clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .link(lk)
  );
  fcag_link_monitor #(.OSC_SETTLE_CYC(OSC)) u_fcag_link_monitor
  (
    .clk(clk), .reset_n(reset_n), .rstPinN(lk.rstPinN), .supplyHigh(lk.supplyHigh),
    .supplyLow(lk.supplyLow), .modeSel(lk.modeSel), .busReq(lk.busReq),
    .busWrite(lk.busWrite), .busAddr(lk.busAddr), .busAck(lk.busAck),
    .busRdata(lk.busRdata), .busExt(lk.busExt), .hvFlag(lk.hvFlag), .standby(lk.standby)
  );

  task automatic report_and_stop();
    $display("checks %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    nTests++;
    if (g !== e)
    begin
      errorCnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask

  // axi write; the extra edge keeps bready from toggling twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // one byte access on the link, status returned once the sequencer is idle
  task automatic acc(input logic w, input logic [16:0] a, input logic [7:0] v);
    wr(`FCAG_OFF_ADDR, {15'h0, a});
    wr(`FCAG_OFF_WDATA, {24'h0, v});
    wr(`FCAG_OFF_CMD, {30'h0, w, 1'b1});
    do rd(`FCAG_OFF_STATUS, st, r); while (st[`FCAG_ST_BUSY_BIT]);
  endtask

  // wait on one event: raise, mask, clear
  task automatic waitIrq(input int b);
    wr(`FCAG_OFF_IRQ_EN, 32'h1 << b);
    do rd(`FCAG_OFF_IRQ_ST, d, r); while (!d[b]);
    chk1(irq, 1'b1);
    wr(`FCAG_OFF_IRQ_EN, 32'h0);
    chk1(irq, 1'b0);
    wr(`FCAG_OFF_IRQ_CLR, 32'h1 << b);
    wr(`FCAG_OFF_IRQ_EN, 32'h1 << b);
    chk1(irq, 1'b0);
  endtask

  // stale events cleared first so a wait cannot end early
  task automatic setc(input logic [4:0] v, input logic sup);
    wr(`FCAG_OFF_IRQ_CLR, 32'hf);
    wr(`FCAG_OFF_CTRL, {27'h0, v});
    if (sup)
      waitIrq(`FCAG_IRQ_SUP_BIT);
  endtask

  // program bit seen, and a ceiling far above the several hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (pc[0])
      sawP <= 1'b1;
    if (cycles == 20000)
    begin
      errorCnt++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    waitIrq(`FCAG_IRQ_PWR_BIT);
    chk8(pc, `FCAG_PCTL_RST & 8'h7f);
    rd(8'h20, d, r);
    chk8({6'h0, r}, 8'h02);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      setc({3'h0, m[1:0]}, 1'b0);
      foreach (adr[i])
      begin
        acc(1'b0, adr[i], 8'h0);
        x = (adr[i] == 17'h0ff80) ? (m == 1 || m == 2) : (m == 1);
        chk1(st[`FCAG_ST_EXT_BIT], x);
        chk8(st[7:0], x ? adr[i][7:0] ^ 8'h5a : (adr[i] >= 17'h0f780 ? 8'hff : adr[i][7:0]));
      end
    end
    $display("test decode done");
    setc(5'h06, 1'b1);
    rd(`FCAG_OFF_STATUS, d, r);
    chk1(d[`FCAG_ST_HV_BIT], 1'b1);
    acc(1'b0, 17'h0ff80, 8'h0);
    chk8(st[7:0], `FCAG_PCTL_RST);
    acc(1'b1, 17'h0ff82, 8'h3c);
    chk8(es1, 8'h3c);
    acc(1'b0, 17'h0ff82, 8'h0);
    chk8(st[7:0], 8'h3c);
    chk1(st[`FCAG_ST_EXT_BIT], 1'b0);
    acc(1'b1, 17'h0ff80, 8'h83);
    acc(1'b0, 17'h0ff80, 8'h0);
    chk8(st[7:0], `FCAG_PCTL_RST);
    setc(5'h07, 1'b0);
    acc(1'b1, 17'h0ff83, 8'h11);
    acc(1'b0, 17'h0ff83, 8'h0);
    chk8(st[7:0], 8'h11);
    setc(5'h05, 1'b0);
    acc(1'b1, 17'h0ff83, 8'h22);
    acc(1'b0, 17'h0ff83, 8'h0);
    chk8(st[7:0], 8'hff);
    chk8(es2, 8'h11);
    $display("test registers done");
    setc(5'h16, 1'b0);
    acc(1'b1, 17'h0ff80, 8'h81);
    waitIrq(`FCAG_IRQ_WDOG_BIT);
    repeat (25) @(posedge clk); // hold sequence: 10 + 10 cycles
    chk8({6'h0, pc[1:0]}, 8'h0);
    chk1(sawP, 1'b1);
    setc(5'h02, 1'b1);
    chk8(es1, `FCAG_EBS_RST);
    rd(`FCAG_OFF_STATUS, d, r);
    chk1(d[`FCAG_ST_HV_BIT], 1'b0);
    $display("test watchdog done");
    setc(5'h0a, 1'b1);
    chk1(hwStandby, 1'b1);
    chk1(lk.standby, 1'b1);
    setc(5'h02, 1'b1);
    chk1(hwStandby, 1'b0);
    $display("test standby done");
    report_and_stop();
  end
endmodule // test_flash_ctrl_reg_access_gate
`default_nettype wire
